//--- inc/pwr_sleep_pkg.sv
// Function
// R01: bit 1 of power control written one halts processor
// R02: trigger bit one enters selected low-power state
// R03: trigger bit always reads back zero
// R04: any interrupt clears trigger, returns to active
// R05: sleep bit 7 enables usb, zero resets it
// R06: waking from deep states clears usb enable
// R07: bit 6 shows crystal oscillator stable
// R08: bit 5 shows fast rc oscillator stable
// R09: bits 4:3 give last reset cause
// R10: latest reset cause overwrites any earlier one
// R11: fast oscillator power-down bit resets to one
// R12: clock source toggle clears power-down bit
// R13: power-down set deferred until calibration ends
// R14: power-down powers off the unselected fast oscillator
// R15: mode field encodes halt, light, deep, deepest
// R16: mode field cleared once a sleep state entered
// R17: writes to read-only flags and cause ignored
package pwr_sleep_pkg;

    localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'hbe;

    // power control fields
    localparam int PC_TRIGGER_BIT = 0;
    localparam int PC_RESERVED_BIT = 1;
    localparam int PC_SPARE_LSB = 2;
    localparam logic [5:0] PC_SPARE_RESET = 6'h00;

    // sleep control fields
    localparam int SC_USB_EN_BIT = 7;
    localparam int SC_CRYSTAL_OSC_STABLE_BIT = 6;
    localparam int SC_FAST_RC_OSC_STABLE_BIT = 5;
    localparam int SC_CAUSE_LSB = 3;
    localparam int SC_UNUSED_FAST_OSC_POWERDOWN_BIT = 2;
    localparam int SC_MODE_LSB = 0;
    localparam logic SC_USB_EN_RESET = 1'b0;
    localparam logic SC_UNUSED_FAST_OSC_POWERDOWN_RESET = 1'b1;
    localparam logic [1:0] SC_MODE_RESET = 2'h0;

    // reset cause codes
    localparam logic [1:0] CAUSE_POWER_ON = 2'h0;
    localparam logic [1:0] CAUSE_EXTERNAL = 2'h1;
    localparam logic [1:0] CAUSE_WATCHDOG = 2'h2;

    // mode field codes
    localparam logic [1:0] MODE_HALT = 2'h0;
    localparam logic [1:0] MODE_LIGHT = 2'h1;
    localparam logic [1:0] MODE_DEEP = 2'h2;
    localparam logic [1:0] MODE_DEEPEST = 2'h3;

    typedef enum logic [2:0] {
        active_state = 3'b000,
        cpu_halt_state = 3'b001,
        light_sleep_state = 3'b010,
        deep_sleep_state = 3'b011,
        deepest_sleep_state = 3'b100
    } pwr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage

//--- rtl/power_mode_sleep_control.sv
`timescale 1ns/10ps
module power_mode_sleep_control
    import pwr_sleep_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // special function register access
    input sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // reset sources
    input wire logic ext_rst_b,
    input wire logic wdt_expire,
    // wake and clock control
    input wire logic irq_req,
    input wire logic system_clock_source_select,
    input wire logic calib_busy,
    // oscillator status from analog
    input wire logic crystal_osc_stable,
    input wire logic fast_rc_osc_stable,
    // power outputs
    output pwr_state_t power_state,
    output logic cpu_stopped,
    output logic usb_enable,
    output logic usb_reset,
    output logic crystal_osc_powerdown,
    output logic rc_osc_powerdown
);

    logic rst_meta_r, rst_sync_b;
    logic [1:0] ext_sync_r, fast_crystal_oscillator_sync_r, hfrc_sync_r;
    logic ext_prev_r, clk_sel_prev_r;
    logic soft_rst, ext_evt, toggle;
    logic wr_pc, wr_sc, rd_pc, rd_sc;
    logic [5:0] pc_spare_r;
    logic stop_r;
    logic usb_en_r, unused_fast_osc_powerdown_r, pd_pending_r;
    logic [1:0] cause_r, mode_r;
    logic [7:0] rdata_r;
    pwr_state_t state_r;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b <= rst_meta_r;
        end
    end

    // pin and analog inputs through two flops
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ext_sync_r <= 2'h3;
            fast_crystal_oscillator_sync_r <= 2'h0;
            hfrc_sync_r <= 2'h0;
            ext_prev_r <= 1'b1;
            clk_sel_prev_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[0], ext_rst_b};
            fast_crystal_oscillator_sync_r <= {fast_crystal_oscillator_sync_r[0], crystal_osc_stable};
            hfrc_sync_r <= {hfrc_sync_r[0], fast_rc_osc_stable};
            ext_prev_r <= ext_sync_r[1];
            clk_sel_prev_r <= system_clock_source_select;
        end
    end

    assign ext_evt = ext_prev_r && !ext_sync_r[1];
    assign soft_rst = ext_evt || wdt_expire;
    assign toggle = system_clock_source_select != clk_sel_prev_r;
    assign wr_pc = sfr_req.wr && sfr_req.addr == POWER_CONTROL_ADDR;
    assign wr_sc = sfr_req.wr && sfr_req.addr == SLEEP_CONTROL_ADDR;
    assign rd_pc = sfr_req.rd && sfr_req.addr == POWER_CONTROL_ADDR;
    assign rd_sc = sfr_req.rd && sfr_req.addr == SLEEP_CONTROL_ADDR;

    // latest cause kept across external and watchdog resets
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cause_r <= CAUSE_POWER_ON; // see R09
        end else if (wdt_expire) begin
            cause_r <= CAUSE_WATCHDOG; // see R10
        end else if (ext_evt) begin
            cause_r <= CAUSE_EXTERNAL; // see R10
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pc_spare_r <= PC_SPARE_RESET;
            stop_r <= 1'b0;
        end else if (soft_rst) begin
            pc_spare_r <= PC_SPARE_RESET;
            stop_r <= 1'b0;
        end else if (wr_pc) begin
            pc_spare_r <= sfr_req.wdata[7:PC_SPARE_LSB];
            if (sfr_req.wdata[PC_RESERVED_BIT]) begin
                stop_r <= 1'b1; // see R01
            end
        end
    end

    // power state sequencer; trigger bit lives here as the state
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state_r <= active_state;
        end else if (soft_rst) begin
            state_r <= active_state;
        end else if (state_r != active_state) begin
            if (irq_req) begin
                state_r <= active_state; // see R04
            end
        end else if (wr_pc && sfr_req.wdata[PC_TRIGGER_BIT] && !irq_req) begin
            case (mode_r) // see R02, R15
                MODE_HALT: state_r <= cpu_halt_state;
                MODE_LIGHT: state_r <= light_sleep_state;
                MODE_DEEP: state_r <= deep_sleep_state;
                MODE_DEEPEST: state_r <= deepest_sleep_state;
                default: state_r <= active_state;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode_r <= SC_MODE_RESET;
        end else if (soft_rst) begin
            mode_r <= SC_MODE_RESET;
        end else if (state_r != active_state && state_r != cpu_halt_state) begin
            mode_r <= MODE_HALT; // see R16
        end else if (wr_sc) begin
            mode_r <= sfr_req.wdata[SC_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            usb_en_r <= SC_USB_EN_RESET;
        end else if (soft_rst) begin
            usb_en_r <= SC_USB_EN_RESET;
        end else if (irq_req && (state_r == deep_sleep_state
                                 || state_r == deepest_sleep_state)) begin
            usb_en_r <= 1'b0; // see R06
        end else if (wr_sc) begin
            usb_en_r <= sfr_req.wdata[SC_USB_EN_BIT]; // see R05
        end
    end

    // power-down bit, with a set held back during calibration
    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            unused_fast_osc_powerdown_r <= SC_UNUSED_FAST_OSC_POWERDOWN_RESET; // see R11
            pd_pending_r <= 1'b0;
        end else if (soft_rst) begin
            unused_fast_osc_powerdown_r <= SC_UNUSED_FAST_OSC_POWERDOWN_RESET; // see R11
            pd_pending_r <= 1'b0;
        end else if (toggle) begin
            unused_fast_osc_powerdown_r <= 1'b0; // see R12
            pd_pending_r <= 1'b0;
        end else if (wr_sc) begin
            if (!sfr_req.wdata[SC_UNUSED_FAST_OSC_POWERDOWN_BIT]) begin
                unused_fast_osc_powerdown_r <= 1'b0;
                pd_pending_r <= 1'b0;
            end else if (calib_busy) begin
                pd_pending_r <= 1'b1; // see R13
            end else begin
                unused_fast_osc_powerdown_r <= 1'b1;
                pd_pending_r <= 1'b0;
            end
        end else if (pd_pending_r && !calib_busy) begin
            unused_fast_osc_powerdown_r <= 1'b1; // see R13
            pd_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rdata_r <= 8'h00;
        end else if (rd_pc) begin
            rdata_r <= {pc_spare_r, 2'h0}; // see R03
        end else if (rd_sc) begin
            // status flags and cause come only from hardware; see R17
            rdata_r <= {usb_en_r, fast_crystal_oscillator_sync_r[1], hfrc_sync_r[1], cause_r,
                        unused_fast_osc_powerdown_r, mode_r}; // see R07, R08, R09
        end
    end

    // halted or asleep: both fast oscillators off in light, deep and deepest sleep
    always_comb begin
        crystal_osc_powerdown = 1'b0;
        rc_osc_powerdown = 1'b0;
        if (state_r != active_state && state_r != cpu_halt_state) begin
            crystal_osc_powerdown = 1'b1;
            rc_osc_powerdown = 1'b1;
        end else if (unused_fast_osc_powerdown_r) begin
            crystal_osc_powerdown = system_clock_source_select; // see R14
            rc_osc_powerdown = !system_clock_source_select; // see R14
        end
    end

    assign sfr_rdata = rdata_r;
    assign power_state = state_r;
    assign cpu_stopped = stop_r;
    assign usb_enable = usb_en_r;
    assign usb_reset = !usb_en_r; // see R05

    a_reserved_stop: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R01
        wr_pc && sfr_req.wdata[PC_RESERVED_BIT] && !soft_rst |=> cpu_stopped)
        else $error("reserved bit write did not stop cpu");

    a_trigger_enters: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R02
        wr_pc && sfr_req.wdata[PC_TRIGGER_BIT] && state_r == active_state && !irq_req
        && !soft_rst && mode_r == MODE_DEEP |=> power_state == deep_sleep_state)
        else $error("trigger did not enter selected state");

    a_trigger_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R03
        rd_pc |=> sfr_rdata[1:0] == 2'h0)
        else $error("trigger bit read back nonzero");

    a_irq_wakes: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R04
        irq_req && power_state != active_state |=> power_state == active_state)
        else $error("interrupt did not wake device");

    a_deep_wake_usb: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R06
        irq_req && (power_state == deep_sleep_state || power_state == deepest_sleep_state)
        |=> !usb_enable && usb_reset)
        else $error("usb enable survived deep wake");

    a_cause_latest: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R10
        wdt_expire || ext_evt
        |=> cause_r == ($past(wdt_expire) ? CAUSE_WATCHDOG : CAUSE_EXTERNAL))
        else $error("reset cause not latest");

    a_pd_toggle: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R12
        toggle && !soft_rst |=> !unused_fast_osc_powerdown_r && !pd_pending_r)
        else $error("toggle did not clear power-down");

    a_pd_defer: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R13
        wr_sc && sfr_req.wdata[SC_UNUSED_FAST_OSC_POWERDOWN_BIT] && calib_busy && !unused_fast_osc_powerdown_r
        && !toggle && !soft_rst |=> !unused_fast_osc_powerdown_r && pd_pending_r)
        else $error("power-down not deferred during calibration");

    a_mode_cleared: assert property (@(posedge sys_clk) disable iff (!rst_sync_b) // see R16
        power_state == light_sleep_state && !soft_rst |=> mode_r == MODE_HALT)
        else $error("mode not cleared in sleep");

endmodule // power_mode_sleep_control

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
    import pwr_sleep_pkg::*;
    logic sys_clk, rst_b, ext_rst_b, wdt_expire, irq_req, clk_sel, calib_busy, xstb, rstb;
    sfr_req_t req;
    logic [7:0] rdata;
    logic [7:0] d;
    pwr_state_t power_state;
    logic cpu_stopped, usb_enable, usb_reset, fast_crystal_oscillator_pd, rc_pd;
    int miscompares, tests_run;

    power_mode_sleep_control dut (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .sfr_req(req),
        .sfr_rdata(rdata),
        .ext_rst_b(ext_rst_b),
        .wdt_expire(wdt_expire),
        .irq_req(irq_req),
        .system_clock_source_select(clk_sel),
        .calib_busy(calib_busy),
        .crystal_osc_stable(xstb),
        .fast_rc_osc_stable(rstb),
        .power_state(power_state),
        .cpu_stopped(cpu_stopped),
        .usb_enable(usb_enable),
        .usb_reset(usb_reset),
        .crystal_osc_powerdown(fast_crystal_oscillator_pd),
        .rc_osc_powerdown(rc_pd)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task end_sim;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one-cycle strobes, request launched just after an edge
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        cyc(1);
        req.wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        cyc(1);
        req.rd = 1'b0;
        v = rdata;
    endtask

    task wake;
        irq_req = 1'b1;
        cyc(1);
        irq_req = 1'b0;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        $display("[ERR] run_time expected done seen timeout");
        end_sim;
    end

    initial begin
        rst_b = 1'b0;
        ext_rst_b = 1'b1;
        wdt_expire = 1'b0;
        irq_req = 1'b0;
        clk_sel = 1'b0;
        calib_busy = 1'b0;
        xstb = 1'b1;
        rstb = 1'b0;
        req = '0;
        cyc(4);
        rst_b = 1'b1;
        cyc(3);
        rd(8'hbe, d); chk("sleep_reset", 8'h44, d);
        rd(8'h87, d); chk("power_reset", 8'h00, d);
        chk("cpu_stopped", 8'h00, {7'h0, cpu_stopped});
        wr(8'hbe, 8'h78);
        rd(8'hbe, d); chk("sleep_ro", 8'h40, d);
        chk("pd_clear", 8'h00, {6'h0, fast_crystal_oscillator_pd, rc_pd});
        wr(8'hbe, 8'h04);
        chk("pd_set", 8'h01, {6'h0, fast_crystal_oscillator_pd, rc_pd});
        clk_sel = 1'b1;
        cyc(2);
        rd(8'hbe, d); chk("pd_toggle", 8'h40, d);
        calib_busy = 1'b1;
        wr(8'hbe, 8'h04);
        cyc(2);
        rd(8'hbe, d); chk("pd_defer", 8'h40, d);
        chk("pd_defer_pins", 8'h00, {6'h0, fast_crystal_oscillator_pd, rc_pd});
        calib_busy = 1'b0;
        cyc(3);
        chk("pd_late_pins", 8'h02, {6'h0, fast_crystal_oscillator_pd, rc_pd});
        clk_sel = 1'b0;
        cyc(2);
        wr(8'h87, 8'hfd);
        chk("halt_state", 8'h01, {5'h0, power_state});
        rd(8'h87, d); chk("power_read", 8'hfc, d);
        wake;
        chk("halt_wake", 8'h00, {5'h0, power_state});
        for (int m = 1; m < 4; m++) begin
            wr(8'hbe, 8'h80 | 8'(m));
            chk("usb_on", 8'h02, {6'h0, usb_enable, usb_reset});
            wr(8'h87, 8'h01);
            chk("sleep_state", 8'(m) + 8'h01, {5'h0, power_state});
            chk("sleep_pd", 8'h03, {6'h0, fast_crystal_oscillator_pd, rc_pd});
            cyc(2);
            rd(8'hbe, d); chk("mode_cleared", 8'hc0, d);
            wake;
            chk("woken", 8'h00, {5'h0, power_state});
            chk("usb_after", (m > 1) ? 8'h00 : 8'h01, {7'h0, usb_enable});
        end
        wr(8'hbe, 8'h00);
        chk("usb_off", 8'h01, {7'h0, usb_reset});
        rd(8'h10, d); chk("unmapped_rd", 8'hc0, d);
        wr(8'hbf, 8'h80);
        chk("unmapped_wr", 8'h00, {7'h0, usb_enable});
        rstb = 1'b1;
        wdt_expire = 1'b1;
        cyc(1);
        wdt_expire = 1'b0;
        cyc(4);
        rd(8'hbe, d); chk("cause_wdt", 8'h74, d);
        ext_rst_b = 1'b0;
        cyc(2);
        ext_rst_b = 1'b1;
        cyc(6);
        rd(8'hbe, d); chk("cause_ext", 8'h6c, d);
        wr(8'h87, 8'h02);
        cyc(1);
        chk("cpu_stop", 8'h01, {7'h0, cpu_stopped});
        end_sim;
    end
endmodule // tb
